// [src/unified_writeback_cache.sv]
// Unified instruction and data cache between the core and the memory bus.
// Assumes core requests and memory answers arrive on clk; memory answers
// are looked at only on bus ticks, which pace the slower external bus.
`timescale 1ns/1ps
module unified_writeback_cache (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   clock_ratio_select,
  input  wire logic                   write_back_mode,
  input  cache_pkg::core_req_type     core_req,
  output cache_pkg::mem_req_type      mem_req_q,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata,
  output logic                        core_ready_q,
  output logic                        core_ack_q,
  output logic [31:0]                 core_rdata_q,
  output logic                        bus_clk_q
);
  import cache_pkg::*;

  // Reset release through two flip-flops.
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Lowest set bit of a dirty mask, so words go out in address order.
  function automatic logic [1:0] first_dirty(input logic [3:0] mask);
    logic [1:0] r;
    r = 2'h0;
    for (int k = WORDS - 1; k >= 0; k--)
      if (mask[k]) r = 2'(k);
    return r;
  endfunction : first_dirty

  // Victim: an invalid way if any, otherwise the oldest way.
  function automatic logic [1:0] pick_victim(input logic [3:0] vld, input age_vec_type ages);
    logic [1:0] v;
    v = 2'h0;
    for (int k = WAYS - 1; k >= 0; k--)
      if (ages[k] == AGE_OLDEST) v = 2'(k);
    for (int k = WAYS - 1; k >= 0; k--)
      if (!vld[k]) v = 2'(k);
    return v;
  endfunction : pick_victim

  // Make one way the newest; ways younger than it age by one.
  function automatic age_vec_type lru_touch(input age_vec_type ages, input logic [1:0] w);
    age_vec_type n;
    n = ages;
    for (int k = 0; k < WAYS; k++)
      if (2'(k) == w) n[k] = 2'h0;
      else if (ages[k] < ages[w]) n[k] = ages[k] + 2'h1;
    return n;
  endfunction : lru_touch

  // Strap pin passes three flip-flops; the level is taken at each bus cycle end where the last two agree.
  logic strap_s1_q, strap_s2_q, strap_s3_q;  // Strap synchroniser chain.
  logic ratio_3x_q, ratio_3x_d;              // Captured ratio, 1 means 3X.
  logic strap_done_q, strap_done_d;          // Ratio has been captured.
  logic [1:0] div_q, div_d;                  // Core cycles within a bus cycle.
  logic bus_clk_d;
  logic bus_tick;                            // First core cycle of a bus cycle.

  // Ratio capture and bus divider next state.
  always_comb
  begin
    ratio_3x_d   = ratio_3x_q;
    strap_done_d = strap_done_q;
    if (div_q == (ratio_3x_q ? RATIO_3X_LAST : RATIO_2X_LAST)) div_d = 2'h0;
    else div_d = div_q + 2'h1;
    bus_clk_d = (div_d == 2'h0);
    // Strap selects ratio.
    // The chain's reset levels agree with each other, so a one-shot capture would
    // miss a low strap; the ratio follows the pin instead, switching only where a
    // bus cycle ends so that no bus cycle is cut short or stretched.
    if (bus_clk_d && strap_s2_q == strap_s3_q)
    begin
      ratio_3x_d   = strap_s3_q;
      strap_done_d = 1'b1;
    end
  end
  assign bus_tick = (div_q == 2'h0);

  // Ratio and divider registers; the strap default models the pull-up.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      strap_s1_q   <= STRAP_RESET;
      strap_s2_q   <= STRAP_RESET;
      strap_s3_q   <= STRAP_RESET;
      ratio_3x_q   <= STRAP_RESET;
      strap_done_q <= 1'b0;
      div_q        <= 2'h0;
      bus_clk_q    <= 1'b0;
    end
    else
    begin
      strap_s1_q   <= clock_ratio_select;
      strap_s2_q   <= strap_s1_q;
      strap_s3_q   <= strap_s2_q;
      ratio_3x_q   <= ratio_3x_d;
      strap_done_q <= strap_done_d;
      div_q        <= div_d;
      bus_clk_q    <= bus_clk_d;
    end
  end

  logic [31:0]  data_q  [SETS][WAYS][WORDS];  // Line data, no reset needed.
  tag_vec_type  tag_q   [SETS];               // Stored upper address bits.
  logic [3:0]   valid_q [SETS];               // One valid bit per line.
  logic [3:0]   dirty_q [SETS][WAYS];         // One dirty bit per doubleword.
  age_vec_type  lru_q   [SETS];               // LRU ranks per set.

  logic [INDEX_BITS-1:0] req_set;
  logic [TAG_BITS-1:0]   req_tag;
  logic [1:0]            req_word;
  logic [3:0]            hit_vec;
  logic                  hit_any;
  logic [1:0]            hit_way;
  logic [31:0]           hit_data;
  logic                  take;
  assign req_set  = core_req.addr[TAG_LSB-1:OFFSET_BITS];
  assign req_tag  = core_req.addr[31:TAG_LSB];
  assign req_word = core_req.addr[OFFSET_BITS-1:WORD_LSB];
  assign take     = core_ready_q && core_req.valid;

  // Tag compare in every way of the addressed set.
  genvar g;
  generate
    for (g = 0; g < WAYS; g++)
    begin : g_cmp
      assign hit_vec[g] = valid_q[req_set][g] && tag_q[req_set][g] == req_tag;
    end
  endgenerate
  assign hit_any  = |hit_vec;
  assign hit_way  = first_dirty(hit_vec);
  assign hit_data = data_q[req_set][hit_way][req_word];

  state_type             state_q, state_d;
  core_req_type          cur_q, cur_d;        // Access being serviced.
  logic [1:0]            way_q, way_d;        // Way being evicted and filled.
  logic [3:0]            wbmask_q, wbmask_d;  // Dirty words still to write back.
  logic [1:0]            word_q, word_d;      // Word on the bus.
  mem_req_type           mreq_d;
  logic                  ack_d, ready_d;
  logic [31:0]           rdata_d;
  logic [INDEX_BITS-1:0] cur_set;
  logic                  dw_en, dirty_en, line_en, lru_en;
  logic [INDEX_BITS-1:0] dw_set;
  logic [1:0]            dw_way, dw_word;
  logic [31:0]           dw_data;
  assign cur_set = cur_q.addr[TAG_LSB-1:OFFSET_BITS];

  // Access sequencing: read hits and write-back write hits finish at once; misses and write-through writes walk the bus.
  always_comb
  begin
    state_d  = state_q;
    cur_d    = cur_q;
    way_d    = way_q;
    wbmask_d = wbmask_q;
    word_d   = word_q;
    mreq_d   = mem_req_q;
    ack_d    = 1'b0;
    rdata_d  = core_rdata_q;
    dw_en    = 1'b0;
    dirty_en = 1'b0;
    line_en  = 1'b0;
    lru_en   = 1'b0;
    dw_set   = req_set;
    dw_way   = hit_way;
    dw_word  = req_word;
    dw_data  = core_req.wdata;
    case (state_q)
      ST_IDLE:
      begin
        if (take)
        begin
          cur_d = core_req;
          if (!core_req.write && hit_any)
          begin
            rdata_d = hit_data;
            ack_d   = 1'b1;
            lru_en  = 1'b1;
          end
          else if (!core_req.write)
          begin
            way_d    = pick_victim(valid_q[req_set], lru_q[req_set]);
            wbmask_d = valid_q[req_set][way_d] ? dirty_q[req_set][way_d] : 4'h0;
            word_d   = 2'h0;
            state_d  = (wbmask_d != 4'h0) ? ST_WRBACK : ST_FILL;
          end
          else if (hit_any)
          begin
            dw_en  = 1'b1;
            lru_en = 1'b1;
            if (write_back_mode)
            begin
              dirty_en = 1'b1;
              ack_d    = 1'b1;
            end
            else state_d = ST_WTHRU;
          end
          else state_d = ST_WTHRU;
        end
      end
      ST_WTHRU:
      begin
        if (bus_tick && mem_req_q.valid && mem_ack)
        begin
          mreq_d.valid = 1'b0;
          ack_d        = 1'b1;
          state_d      = ST_IDLE;
        end
        else if (bus_tick && !mem_req_q.valid)
          mreq_d = '{valid: 1'b1, write: 1'b1, addr: cur_q.addr, data: cur_q.wdata};
      end
      ST_WRBACK:
      begin
        if (bus_tick && mem_req_q.valid && mem_ack)
        begin
          mreq_d.valid     = 1'b0;
          wbmask_d[word_q] = 1'b0;
          if (wbmask_d == 4'h0) state_d = ST_FILL;
          word_d = 2'h0;
        end
        else if (bus_tick && !mem_req_q.valid)
        begin
          word_d = first_dirty(wbmask_q);
          mreq_d = '{valid: 1'b1, write: 1'b1,
                     addr: {tag_q[cur_set][way_q], cur_set, word_d, 2'h0},
                     data: data_q[cur_set][way_q][word_d]};
        end
      end
      ST_FILL:
      begin
        dw_set  = cur_set;
        dw_way  = way_q;
        dw_word = word_q;
        dw_data = mem_rdata;
        if (bus_tick && mem_req_q.valid && mem_ack)
        begin
          mreq_d.valid = 1'b0;
          dw_en        = 1'b1;
          word_d       = word_q + 2'h1;
          if (word_q == 2'(WORDS - 1))
          begin
            line_en = 1'b1;
            lru_en  = 1'b1;
            ack_d   = 1'b1;
            rdata_d = (cur_q.addr[OFFSET_BITS-1:WORD_LSB] == word_q) ? mem_rdata :
                      data_q[cur_set][way_q][cur_q.addr[OFFSET_BITS-1:WORD_LSB]];
            state_d = ST_IDLE;
          end
        end
        else if (bus_tick && !mem_req_q.valid)
          mreq_d = '{valid: 1'b1, write: 1'b0,
                     addr: {cur_q.addr[31:OFFSET_BITS], word_q, 2'h0}, data: 32'h0};
      end
      default: state_d = ST_IDLE;
    endcase
    ready_d = (state_d == ST_IDLE);
  end

  // Control registers and core-side outputs.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q      <= ST_IDLE;
      cur_q        <= '0;
      way_q        <= 2'h0;
      wbmask_q     <= 4'h0;
      word_q       <= 2'h0;
      mem_req_q    <= '0;
      core_ack_q   <= 1'b0;
      core_rdata_q <= 32'h0;
      core_ready_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      cur_q        <= cur_d;
      way_q        <= way_d;
      wbmask_q     <= wbmask_d;
      word_q       <= word_d;
      mem_req_q    <= mreq_d;
      core_ack_q   <= ack_d;
      core_rdata_q <= rdata_d;
      core_ready_q <= ready_d;
    end
  end

  // Data array; contents are meaningless until the valid bit is set.
  always_ff @(posedge clk)
  begin
    if (dw_en) data_q[dw_set][dw_way][dw_word] <= dw_data;
  end

  // Tag, valid, dirty and LRU state.
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      for (int s = 0; s < SETS; s++)
      begin
        valid_q[s] <= 4'h0;
        tag_q[s]   <= '0;
        lru_q[s]   <= {2'h3, 2'h2, 2'h1, 2'h0};
        for (int w = 0; w < WAYS; w++) dirty_q[s][w] <= 4'h0;
      end
    end
    else
    begin
      if (dirty_en) dirty_q[dw_set][dw_way][dw_word] <= 1'b1;
      if (line_en)
      begin
        valid_q[dw_set][dw_way] <= 1'b1;
        tag_q[dw_set][dw_way]   <= cur_q.addr[31:TAG_LSB];
        dirty_q[dw_set][dw_way] <= 4'h0;
      end
      if (lru_en) lru_q[dw_set] <= lru_touch(lru_q[dw_set], dw_way);
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  a_read_hit_ack: assert property (take && !core_req.write && hit_any
    |=> core_ack_q && core_rdata_q == $past(hit_data)) else $error("read hit not answered");
  a_wb_hit_quiet: assert property (take && core_req.write && hit_any && write_back_mode
    |=> core_ack_q && state_q == ST_IDLE && !mem_req_q.valid) else $error("write hit went out");
  a_wt_write_out: assert property (take && core_req.write && !write_back_mode
    |-> ##[1:4] (mem_req_q.valid && mem_req_q.write && mem_req_q.addr == cur_q.addr))
    else $error("write-through write missing");
  a_no_write_fill: assert property (state_q == ST_WTHRU
    |-> !(mem_req_q.valid && !mem_req_q.write)) else $error("write miss filled");
  a_only_dirty_out: assert property (state_q == ST_WRBACK && mem_req_q.valid
    |-> wbmask_q[mem_req_q.addr[3:2]]) else $error("clean word written back");
  a_wb_writes_why: assert property (mem_req_q.valid && mem_req_q.write && write_back_mode
    |-> state_q == ST_WRBACK || state_q == ST_WTHRU) else $error("stray external write");
  a_tick_ratio3: assert property (bus_tick && ratio_3x_q
    |=> !bus_tick ##1 !bus_tick ##1 bus_tick) else $error("bus tick spacing wrong");
  a_req_on_tick: assert property ($rose(mem_req_q.valid) |-> $past(bus_tick))
    else $error("bus request off tick");
  a_fill_valid: assert property (line_en
    |=> valid_q[$past(dw_set)][$past(dw_way)] && dirty_q[$past(dw_set)][$past(dw_way)] == 4'h0)
    else $error("filled line not valid");
  a_dirty_mark: assert property (dirty_en
    |=> dirty_q[$past(dw_set)][$past(dw_way)][$past(dw_word)]) else $error("dirty bit lost");
  a_victim_lru: assert property (take && !core_req.write && !hit_any && &valid_q[req_set]
    |=> lru_q[cur_set][way_q] == AGE_OLDEST) else $error("victim not LRU");
  a_single_hit: assert property ($onehot0(hit_vec)) else $error("tag in two ways");
  a_strap_2x: assert property (strap_done_q && !ratio_3x_q && bus_tick
    |=> !bus_tick ##1 bus_tick) else $error("2X spacing wrong");

  c_read_miss_fill: cover property (state_q == ST_FILL ##[1:40] core_ack_q);
  c_dirty_evict:    cover property (state_q == ST_WRBACK ##[1:80] state_q == ST_FILL);
  c_wt_write:       cover property (state_q == ST_WTHRU ##[1:20] core_ack_q);
  c_back_to_back:   cover property (core_ack_q && take);

endmodule : unified_writeback_cache

// [src/cache_pkg.sv]
// Shared constants, types and states for the unified write-back cache.
// Assumes one core clock, a bus memory that answers on the same clock,
// and a strap pin that picks the core-to-bus clock ratio.
package cache_pkg;

  localparam int CACHE_BYTES = 8192;  // Total data capacity.
  localparam int LINE_BYTES  = 16;    // Bytes in one line.
  localparam int WAYS        = 4;     // Associativity.
  localparam int WORDS       = 4;     // Doublewords in one line.
  localparam int SETS        = CACHE_BYTES / (LINE_BYTES * WAYS);
  localparam int OFFSET_BITS = 4;     // Byte offset within a line.
  localparam int INDEX_BITS  = 7;     // Set index width.
  localparam int TAG_LSB     = OFFSET_BITS + INDEX_BITS;
  localparam int TAG_BITS    = 32 - TAG_LSB;
  localparam int WORD_LSB    = 2;     // Doubleword select position.
  localparam logic [1:0] RATIO_3X_LAST = 2'h2;  // Divider end count at 3X.
  localparam logic [1:0] RATIO_2X_LAST = 2'h1;  // Divider end count at 2X.
  localparam logic       STRAP_RESET   = 1'b1;  // Pulled-up strap level.
  localparam logic [1:0] AGE_OLDEST    = 2'h3;  // LRU rank of the victim.

  // Per-set ranks of the four ways, zero being most recently used.
  typedef logic [WAYS-1:0][1:0] age_vec_type;
  // Per-set tags of the four ways.
  typedef logic [WAYS-1:0][TAG_BITS-1:0] tag_vec_type;

  // A core access: one doubleword read or write.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } core_req_type;

  // A single-doubleword request toward external memory.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_req_type;

  typedef enum logic [1:0] {ST_IDLE, ST_WTHRU, ST_WRBACK, ST_FILL} state_type;

endpackage : cache_pkg

// [verif/mem_model.sv]
// Behavioural external memory on the far side of the cache's bus port.
// Assumes requests are looked at only in bus tick cycles.
`timescale 1ns/1ps
module mem_model (
  input  wire logic              clk,
  input  wire logic              tick,
  input  cache_pkg::mem_req_type req,
  input  wire logic [1:0]        lag,
  output logic                   ack,
  output logic [31:0]            rdata
);
  import cache_pkg::*;
  logic [31:0] store [logic [31:0]];  // Words written by the cache.
  logic [63:0] wlog [$];              // Bus writes seen, {addr, data}.
  int          n_rd = 0;              // Bus reads answered.
  int          waited = 0;            // Ticks spent on this request.

  // Answer only in a tick cycle, after lag extra ticks (slow memory).
  assign ack = req.valid && tick && (waited >= int'(lag));

  // Off the answer the data is the inverted address, so a stale word never matches.
  always @*
  begin
    if (!ack)
      rdata = ~req.addr;
    else if (store.exists(req.addr))
      rdata = store[req.addr];
    else
      rdata = req.addr ^ 32'h5a5a_0000;
  end

  // Record every completed transfer for the bench to judge.
  always @(posedge clk)
  begin
    if (ack)
    begin
      waited <= 0;
      if (req.write)
      begin
        store[req.addr] = req.data;
        wlog.push_back({req.addr, req.data});
      end
      else
        n_rd++;
    end
    else if (req.valid && tick)
      waited <= waited + 1;
  end
endmodule : mem_model

// [verif/testbench.sv]
// Self-checking bench for the unified cache with a memory model.
// Assumes the memory model answers within a few bus ticks.
`timescale 1ns/1ps
module testbench;
  import cache_pkg::*;
  localparam logic [31:0] A  = 32'h0000_1234;  // Plain line.
  localparam logic [31:0] B  = 32'h0000_0100;  // Set used for eviction.
  localparam logic [31:0] D1 = 32'h1111_aaaa;  // Dirty word 1.
  localparam logic [31:0] D3 = 32'h3333_cccc;  // Dirty word 3.
  logic         clk = 1'b0;       // Core clock.
  logic         reset_n = 1'b0;   // Raw reset.
  logic         strap = 1'b1;     // Ratio strap.
  logic         wb = 1'b1;        // Write-back mode.
  logic [1:0]   lag = 2'h0;       // Memory slowness.
  core_req_type req = '0;         // Core request.
  mem_req_type  mreq;             // Bus request.
  logic         mack;             // Bus answer.
  logic [31:0]  mdata;            // Bus read data.
  logic         rdy;              // Core ready.
  logic         cack;             // Core answer.
  logic [31:0]  crd;              // Core read data.
  logic         btick;            // Bus tick.
  int           n_errors = 0;     // Mismatches.
  int           comparisons = 0;  // Compares made.

  // Clock at 20 MHz.
  always #25 clk = ~clk;

  unified_writeback_cache DUT (
    .clk(clk), .reset_n(reset_n), .clock_ratio_select(strap),
    .write_back_mode(wb), .core_req(req), .mem_req_q(mreq), .mem_ack(mack),
    .mem_rdata(mdata), .core_ready_q(rdy), .core_ack_q(cack),
    .core_rdata_q(crd), .bus_clk_q(btick)
  );

  mem_model mem (
    .clk(clk), .tick(btick), .req(mreq), .lag(lag), .ack(mack), .rdata(mdata)
  );

  // Compare one value and count it.
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One core access; n counts cycles from the take to the answer.
  task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output int n);
    @(posedge clk);
    req <= '{1'b1, w, a, d};
    @(negedge clk);
    while (rdy !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    req.valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (cack !== 1'b1 && n < 400);
    if (cack !== 1'b1) check(64'(cack), 64'h1);
    q = crd;
  endtask : access

  // Reset with a given strap; outputs must be quiet meanwhile.
  task automatic do_reset(input logic s);
    @(posedge clk);
    strap <= s;
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    check(64'({mreq.valid, mreq.write, rdy, cack, btick, crd}), 64'h0);
    check({mreq.addr, mreq.data}, 64'h0);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : do_reset

  // Cycles between two bus ticks.
  task automatic tick_gap(input int exp);
    int n;
    @(negedge clk);
    while (btick !== 1'b1)
      @(negedge clk);
    n = 1;
    @(negedge clk);
    while (btick !== 1'b1 && n < 9)
    begin
      @(negedge clk);
      n++;
    end
    check(64'(n), 64'(exp));
  endtask : tick_gap

  // Read miss fills four words, then a hit in the same line takes one cycle.
  task automatic t_fill_hit;
    logic [31:0] q;
    int n;
    int r0;
    r0 = mem.n_rd;
    access(1'b0, A, 32'h0, q, n);
    check(q, A ^ 32'h5a5a_0000);
    check(64'(mem.n_rd - r0), 64'd4);
    access(1'b0, A + 32'h4, 32'h0, q, n);
    check(64'(n), 64'd1);
    check(64'(mem.n_rd - r0), 64'd4);
    $display("test fill_hit done");
  endtask : t_fill_hit

  // Write-back: a hit stays inside, a miss goes out without a fill.
  task automatic t_wb_write;
    logic [31:0] q;
    int n;
    int w0;
    int r0;
    @(posedge clk);
    wb <= 1'b1;
    w0 = mem.wlog.size();
    r0 = mem.n_rd;
    access(1'b1, A, 32'hdead_0001, q, n);
    check(64'(n), 64'd1);
    check(64'(mem.wlog.size() - w0), 64'd0);
    access(1'b1, 32'h3000_0040, 32'hbeef_0002, q, n);
    check(64'(mem.wlog.size() - w0), 64'd1);
    check(mem.wlog[w0], {32'h3000_0040, 32'hbeef_0002});
    check(64'(mem.n_rd - r0), 64'd0);
    $display("test wb_write done");
  endtask : t_wb_write

  // Five tags in one set: the oldest goes, only its dirty words go out.
  task automatic t_evict;
    logic [31:0] q;
    int n;
    int w0;
    int r0;
    access(1'b0, B, 32'h0, q, n);
    access(1'b1, B + 32'h4, D1, q, n);
    access(1'b1, B + 32'hc, D3, q, n);
    lag <= 2'h2;
    w0 = mem.wlog.size();
    for (int k = 1; k < 5; k++)
      access(1'b0, B + 32'(k) * 32'h800, 32'h0, q, n);
    check(64'(mem.wlog.size() - w0), 64'd2);
    check(mem.wlog[w0], {B + 32'h4, D1});
    check(mem.wlog[w0 + 1], {B + 32'hc, D3});
    r0 = mem.n_rd;
    access(1'b0, B + 32'h4, 32'h0, q, n);
    check(q, D1);
    for (int k = 2; k < 5; k++)
      access(1'b0, B + 32'(k) * 32'h800, 32'h0, q, n);
    check(64'(mem.n_rd - r0), 64'd4);
    lag <= 2'h0;
    $display("test evict done");
  endtask : t_evict

  // Write-through: a hit updates the line and goes out as well.
  task automatic t_wthru;
    logic [31:0] q;
    int n;
    int w0;
    @(posedge clk);
    wb <= 1'b0;
    w0 = mem.wlog.size();
    access(1'b1, A, 32'hcafe_0003, q, n);
    check(64'(mem.wlog.size() - w0), 64'd1);
    check(mem.wlog[w0], {A, 32'hcafe_0003});
    access(1'b0, A, 32'h0, q, n);
    check(q, 32'hcafe_0003);
    check(64'(n), 64'd1);
    $display("test wthru done");
  endtask : t_wthru

  // Strap low after a fresh reset gives ticks every two cycles.
  task automatic t_strap_low;
    logic [31:0] q;
    int n;
    int r0;
    do_reset(1'b0);
    tick_gap(2);
    r0 = mem.n_rd;
    access(1'b0, A, 32'h0, q, n);
    check(64'(mem.n_rd - r0), 64'd4);
    $display("test strap_low done");
  endtask : t_strap_low

  // Print the counts and the verdict, then stop.
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // Main sequence.
  initial
  begin
    do_reset(1'b1);
    tick_gap(3);
    $display("test reset_ticks done");
    t_fill_hit();
    t_wb_write();
    t_evict();
    t_wthru();
    t_strap_low();
    wrap_up();
  end

  // Watchdog: the tests need a few thousand cycles at most.
  initial
  begin
    #(50 * 20000);
    n_errors++;
    wrap_up();
  end
endmodule : testbench
